//--- design/spcl_pkg.sv
// constants and types for the shutter pmu control logic
package spcl_pkg;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam int unsigned PRE_MIN = 30;
  localparam int unsigned FAST_MIN = 300;
  localparam int unsigned MS_PER_MIN = 60000;
  localparam int unsigned PRE_MS = PRE_MIN * MS_PER_MIN;
  localparam int unsigned FAST_MS = FAST_MIN * MS_PER_MIN;
  localparam int DIV_W = 17;
  localparam int TMR_W = 25;
  localparam int AW = 8;
  localparam int EV_W = 5;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_STATUS = 8'h04;
  localparam logic [AW-1:0] A_INT_STAT = 8'h08;
  localparam logic [AW-1:0] A_INT_CLR = 8'h0c;
  localparam logic [AW-1:0] A_INT_EN = 8'h10;
  localparam logic [AW-1:0] A_TIMER = 8'h14;
  localparam int CTRL_CHG_EN = 0;
  localparam logic CTRL_CHG_EN_RST = 1'h1;
  localparam logic [EV_W-1:0] INT_EN_RST = 5'h00;
  localparam logic POWER_RST = 1'h1;
  localparam int EV_FAULT = 0;
  localparam int EV_LDO_TSD = 1;
  localparam int EV_BST_TSD = 2;
  localparam int EV_SLEEP = 3;
  localparam int EV_PHASE = 4;
  localparam logic [8:0] FULL_STEP = 9'h100;
  localparam logic [1:0] IN_OPEN = 2'h0;
  localparam logic [1:0] IN_PLUS = 2'h1;
  localparam logic [1:0] IN_MINUS = 2'h2;
  localparam logic [1:0] IN_GND = 2'h3;

  typedef enum logic [2:0] {
    CHG_IDLE = 3'b000,
    CHG_PRE = 3'b001,
    CHG_FAST = 3'b010,
    CHG_TERM = 3'b011,
    CHG_RECHG = 3'b100,
    CHG_FAULT = 3'b101
  } spcl_chg_state_t;

  // switch closed when a field is high
  typedef struct packed {
    logic pos_high;
    logic pos_low;
    logic neg_high;
    logic neg_low;
  } spcl_bridge_t;

  localparam spcl_bridge_t BR_OPEN = 4'h0;
  localparam spcl_bridge_t BR_PLUS = 4'h9;
  localparam spcl_bridge_t BR_MINUS = 4'h6;
  localparam spcl_bridge_t BR_GND = 4'h5;

  typedef struct packed {
    logic vin_present;
    logic input_overvoltage_protect;
    logic above_precharge_threshold;
    logic charge_term_reached;
    logic recharge_needed;
    logic battery_at_reg;
  } spcl_chg_in_t;

  typedef struct packed {
    logic input_power_limit_loop;
    logic vin_low_limit;
    logic thermal_reg;
    logic [7:0] current_scale;
  } spcl_slow_t;
endpackage

//--- design/spcl_top.sv
// shutter pmu control logic: charger, ldo, boost, bridges, apb
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module spcl_top #(
  parameter int unsigned TICK_CYC_P = spcl_pkg::TICK_CYC,
  parameter int unsigned PRE_MS_P = spcl_pkg::PRE_MS,
  parameter int unsigned FAST_MS_P = spcl_pkg::FAST_MS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spcl_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins
  input wire logic boost_enable_pin,
  input wire logic left_bridge_in_low,
  input wire logic left_bridge_in_high,
  input wire logic right_bridge_in_low,
  input wire logic right_bridge_in_high,
  input wire logic sleep_in,
  input wire logic ldo_voltage_select,
  input wire logic wake_request,
  // analog monitors
  input wire spcl_pkg::spcl_chg_in_t chg_in,
  input wire spcl_pkg::spcl_slow_t slow_in,
  input wire logic ldo_thermal_shutdown,
  input wire logic boost_thermal_shutdown,
  // power controls
  output spcl_pkg::spcl_bridge_t left_shutter_sw,
  output spcl_pkg::spcl_bridge_t right_shutter_sw,
  output logic boost_switch_en,
  output logic ldo_enable,
  output logic ldo_3v0_select,
  output logic system_power_on,
  // open-drain charge status
  input wire logic charge_status_n_in,
  output logic charge_status_n_out,
  output logic charge_status_n_oe,
  // interrupt
  output logic irq
);

  // bridge decode shared by both sides
  function automatic spcl_pkg::spcl_bridge_t bridge_dec(
    input logic [1:0] pair,
    input logic boost_on
  );
    spcl_pkg::spcl_bridge_t r;
    r = spcl_pkg::BR_GND;
    if (boost_on) begin
      unique case (pair)
        spcl_pkg::IN_OPEN: r = spcl_pkg::BR_OPEN;
        spcl_pkg::IN_PLUS: r = spcl_pkg::BR_PLUS;
        spcl_pkg::IN_MINUS: r = spcl_pkg::BR_MINUS;
        spcl_pkg::IN_GND: r = spcl_pkg::BR_GND;
      endcase
    end
    return r;
  endfunction

  // state
  spcl_pkg::spcl_chg_state_t chg_q;
  spcl_pkg::spcl_chg_state_t chg_d;
  logic [spcl_pkg::DIV_W-1:0] div_q;
  logic [spcl_pkg::TMR_W-1:0] tmr_q;
  logic [spcl_pkg::TMR_W-1:0] tmr_d;
  logic [7:0] frac_q;
  logic [7:0] frac_d;
  logic powered_q;
  logic powered_d;
  logic sleep_prev_q;
  logic ldo_tsd_prev_q;
  logic bst_tsd_prev_q;
  logic chg_en_q;
  logic [spcl_pkg::EV_W-1:0] int_stat_q;
  logic [spcl_pkg::EV_W-1:0] int_en_q;
  logic [spcl_pkg::EV_W-1:0] ev;

  // divider giving a 1 ms tick
  wire tick = div_q == spcl_pkg::DIV_W'(TICK_CYC_P - 1);

  // proportional slow-down of the timebase
  wire reduce = chg_q == spcl_pkg::CHG_FAST &&
    (slow_in.input_power_limit_loop | slow_in.vin_low_limit |
     slow_in.thermal_reg);
  wire [8:0] step = reduce ? {1'b0, slow_in.current_scale} :
    spcl_pkg::FULL_STEP;
  // fraction carried so a partial step is never lost between ticks
  wire [8:0] frac_sum = {1'b0, frac_q} + step;
  wire advance = tick & frac_sum[8];

  wire timing = chg_q == spcl_pkg::CHG_PRE ||
    chg_q == spcl_pkg::CHG_FAST;
  wire pre_exp = chg_q == spcl_pkg::CHG_PRE &&
    tmr_q >= spcl_pkg::TMR_W'(PRE_MS_P);
  wire fast_exp = chg_q == spcl_pkg::CHG_FAST &&
    tmr_q >= spcl_pkg::TMR_W'(FAST_MS_P);

  // charger held idle while disabled, unpowered at input or overvoltage
  wire chg_allow = chg_en_q & chg_in.vin_present &
    ~chg_in.input_overvoltage_protect;

  // charger phase sequencing
  always_comb begin
    chg_d = chg_q;
    if (!chg_allow) begin
      chg_d = spcl_pkg::CHG_IDLE;
    end else begin
      unique case (chg_q)
        spcl_pkg::CHG_IDLE: begin
          chg_d = chg_in.above_precharge_threshold ?
            spcl_pkg::CHG_FAST : spcl_pkg::CHG_PRE;
        end
        spcl_pkg::CHG_PRE: begin
          if (chg_in.above_precharge_threshold) begin
            chg_d = spcl_pkg::CHG_FAST;
          end else if (pre_exp) begin
            chg_d = spcl_pkg::CHG_FAULT;
          end
        end
        spcl_pkg::CHG_FAST: begin
          if (chg_in.charge_term_reached) begin
            chg_d = spcl_pkg::CHG_TERM;
          end else if (fast_exp) begin
            chg_d = spcl_pkg::CHG_FAULT;
          end
        end
        spcl_pkg::CHG_TERM: begin
          if (chg_in.recharge_needed) begin
            chg_d = spcl_pkg::CHG_RECHG;
          end
        end
        spcl_pkg::CHG_RECHG: begin
          if (chg_in.battery_at_reg) begin
            chg_d = spcl_pkg::CHG_TERM;
          end
        end
        spcl_pkg::CHG_FAULT: chg_d = spcl_pkg::CHG_FAULT;
        default: chg_d = spcl_pkg::CHG_IDLE;
      endcase
    end
  end

  wire phase_change = chg_d != chg_q;

  // safety timer, cleared on every phase change
  always_comb begin
    tmr_d = tmr_q;
    frac_d = frac_q;
    if (phase_change || !timing) begin
      tmr_d = '0;
      frac_d = '0;
    end else if (tick) begin
      frac_d = frac_sum[7:0];
      if (advance) begin
        tmr_d = tmr_q + spcl_pkg::TMR_W'(1);
      end
    end
  end

  // power state and shutdown causes
  // history resets low, so a pin held low over reset is no edge
  wire sleep_fall = sleep_prev_q & ~sleep_in;
  wire shut = ldo_thermal_shutdown | boost_thermal_shutdown |
    sleep_fall;

  always_comb begin
    powered_d = powered_q;
    if (shut) begin
      powered_d = 1'b0;
    end else if (wake_request) begin
      powered_d = 1'b1;
    end
  end

  wire ldo_en_d = powered_d & ~ldo_thermal_shutdown;
  wire boost_on = powered_d & boost_enable_pin &
    ~boost_thermal_shutdown;

  // status switch on only in the precharge, fast charge and termination phases
  wire stat_on = powered_d & ~chg_in.input_overvoltage_protect &
    (chg_d == spcl_pkg::CHG_PRE || chg_d == spcl_pkg::CHG_FAST ||
     chg_d == spcl_pkg::CHG_TERM);

  // events for the sticky status
  assign ev[spcl_pkg::EV_FAULT] = phase_change &&
    chg_d == spcl_pkg::CHG_FAULT;
  assign ev[spcl_pkg::EV_LDO_TSD] = ldo_thermal_shutdown &
    ~ldo_tsd_prev_q;
  assign ev[spcl_pkg::EV_BST_TSD] = boost_thermal_shutdown &
    ~bst_tsd_prev_q;
  assign ev[spcl_pkg::EV_SLEEP] = sleep_fall;
  assign ev[spcl_pkg::EV_PHASE] = phase_change;

  // apb decode
  wire apb_acc = psel & penable;
  wire rd_setup = apb_acc & ~pready;
  wire wr_fire = apb_acc & pready & pwrite;
  wire aligned = paddr[1:0] == 2'h0;
  wire hit_ctrl = aligned && paddr == spcl_pkg::A_CTRL;
  wire hit_status = aligned && paddr == spcl_pkg::A_STATUS;
  wire hit_istat = aligned && paddr == spcl_pkg::A_INT_STAT;
  wire hit_iclr = aligned && paddr == spcl_pkg::A_INT_CLR;
  wire hit_ien = aligned && paddr == spcl_pkg::A_INT_EN;
  wire hit_timer = aligned && paddr == spcl_pkg::A_TIMER;
  wire hit = hit_ctrl | hit_status | hit_istat | hit_iclr |
    hit_ien | hit_timer;

  // bits 7 and 5..3 read the output flops, not their next values; bit 6 reads the status pin input
  wire [31:0] status_word = {24'h000000, ldo_3v0_select,
    charge_status_n_in, boost_switch_en, ldo_enable,
    system_power_on, chg_q};
  wire [31:0] rd_data =
    hit_ctrl ? {31'h00000000, chg_en_q} :
    hit_status ? status_word :
    hit_istat ? {27'h0000000, int_stat_q} :
    hit_ien ? {27'h0000000, int_en_q} :
    hit_timer ? {7'h00, tmr_q} : 32'h00000000;

  wire [spcl_pkg::EV_W-1:0] clr = (wr_fire && hit_iclr) ?
    pwdata[spcl_pkg::EV_W-1:0] : '0;
  // a new event wins over a clear in the same cycle
  wire [spcl_pkg::EV_W-1:0] int_stat_d = (int_stat_q & ~clr) | ev;
  wire irq_d = |(int_stat_d & int_en_q);

  // apb slave: one wait state, data and error with pready
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup & ~hit;
      if (rd_setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_data;
      end
    end
  end

  // software registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chg_en_q <= spcl_pkg::CTRL_CHG_EN_RST;
      int_en_q <= spcl_pkg::INT_EN_RST;
      int_stat_q <= '0;
    end else begin
      if (wr_fire && hit_ctrl) begin
        chg_en_q <= pwdata[spcl_pkg::CTRL_CHG_EN];
      end
      if (wr_fire && hit_ien) begin
        int_en_q <= pwdata[spcl_pkg::EV_W-1:0];
      end
      int_stat_q <= int_stat_d;
    end
  end

  // charger state and timebase
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chg_q <= spcl_pkg::CHG_IDLE;
      div_q <= '0;
      tmr_q <= '0;
      frac_q <= '0;
    end else begin
      chg_q <= chg_d;
      div_q <= tick ? '0 : div_q + spcl_pkg::DIV_W'(1);
      tmr_q <= tmr_d;
      frac_q <= frac_d;
    end
  end

  // edge history and power state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sleep_prev_q <= 1'b0;
      ldo_tsd_prev_q <= 1'b0;
      bst_tsd_prev_q <= 1'b0;
      powered_q <= spcl_pkg::POWER_RST;
    end else begin
      sleep_prev_q <= sleep_in;
      ldo_tsd_prev_q <= ldo_thermal_shutdown;
      bst_tsd_prev_q <= boost_thermal_shutdown;
      powered_q <= powered_d;
    end
  end

  // registered pin outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      left_shutter_sw <= spcl_pkg::BR_GND;
      right_shutter_sw <= spcl_pkg::BR_GND;
      boost_switch_en <= 1'b0;
      ldo_enable <= 1'b0;
      ldo_3v0_select <= 1'b0;
      system_power_on <= 1'b0;
      charge_status_n_out <= 1'b0;
      charge_status_n_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      left_shutter_sw <= bridge_dec({left_bridge_in_high,
        left_bridge_in_low}, boost_on);
      right_shutter_sw <= bridge_dec({right_bridge_in_high,
        right_bridge_in_low}, boost_on);
      boost_switch_en <= boost_on;
      ldo_enable <= ldo_en_d;
      ldo_3v0_select <= ldo_voltage_select;
      system_power_on <= powered_d;
      charge_status_n_out <= 1'b0;
      charge_status_n_oe <= stat_on;
      irq <= irq_d;
    end
  end

endmodule

//--- sim/spcl_host.sv
// host controller model driving the bridge and sleep pins
`timescale 1ns/1ns
module spcl_host (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // commands from bench
  input wire logic flip,
  input wire logic [1:0] cmd_l,
  input wire logic [1:0] cmd_r,
  input wire logic sleep_drop,
  // pins
  output logic [1:0] pair_l,
  output logic [1:0] pair_r,
  output logic sleep_in
);
  logic ph_q;
  logic [1:0] fl;
  assign fl = ph_q ? spcl_pkg::IN_MINUS : spcl_pkg::IN_PLUS;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ph_q <= 1'b0;
      pair_l <= 2'h0;
      pair_r <= 2'h0;
      sleep_in <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      sleep_in <= ~sleep_drop;
      pair_l <= flip ? fl : cmd_l;
      pair_r <= flip ? ~fl : cmd_r;
    end
  end
endmodule

//--- sim/spcl_monitor.sv
// pin level assertions for the shutter pmu control logic
`timescale 1ns/1ns
module spcl_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // host pins and monitors
  input wire logic boost_enable_pin,
  input wire logic left_bridge_in_low,
  input wire logic left_bridge_in_high,
  input wire logic right_bridge_in_low,
  input wire logic right_bridge_in_high,
  input wire logic sleep_in,
  input wire logic ldo_voltage_select,
  input wire spcl_pkg::spcl_chg_in_t chg_in,
  input wire logic ldo_thermal_shutdown,
  input wire logic boost_thermal_shutdown,
  // power controls
  input wire spcl_pkg::spcl_bridge_t left_shutter_sw,
  input wire spcl_pkg::spcl_bridge_t right_shutter_sw,
  input wire logic boost_switch_en,
  input wire logic ldo_enable,
  input wire logic ldo_3v0_select,
  input wire logic system_power_on,
  input wire logic charge_status_n_out,
  input wire logic charge_status_n_oe
);
  localparam spcl_pkg::spcl_bridge_t BRT [4] = '{spcl_pkg::BR_OPEN,
    spcl_pkg::BR_PLUS, spcl_pkg::BR_MINUS, spcl_pkg::BR_GND};
  logic [1:0] pl;
  logic [1:0] pr;
  logic live;
  logic over_v;
  assign pl = {left_bridge_in_high, left_bridge_in_low};
  assign pr = {right_bridge_in_high, right_bridge_in_low};
  assign live = boost_enable_pin && !boost_thermal_shutdown;
  assign over_v = chg_in.input_overvoltage_protect;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence apb_access;
    psel && penable && !pready;
  endsequence
  sequence sleep_fall;
    $past(resetn) && $past(sleep_in) && !sleep_in;
  endsequence
  apb_wait_a: assert property (apb_access |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  br_gnd_a: assert property (!$past(boost_enable_pin) |->
    left_shutter_sw == spcl_pkg::BR_GND && right_shutter_sw == BRT[3])
    else $error("bridges not grounded with boost off");
  br_decode_a: assert property (
    system_power_on && $past(system_power_on) && $past(live) |->
    left_shutter_sw == BRT[$past(pl)] && right_shutter_sw == BRT[$past(pr)])
    else $error("bridge switches differ from input pair");
  stat_ovp_a: assert property ($past(over_v) |-> !charge_status_n_oe)
    else $error("status switch on during overvoltage");
  stat_sleep_a: assert property (!system_power_on |->
    !charge_status_n_oe)
    else $error("status switch on while powered off");
  od_drive_a: assert property (!charge_status_n_out)
    else $error("status pin driven high");
  ldo_sel_a: assert property ($past(resetn) |->
    ldo_3v0_select == $past(ldo_voltage_select))
    else $error("ldo select not following pin");
  ldo_tsd_a: assert property ($rose(ldo_thermal_shutdown) |=>
    !ldo_enable && !system_power_on)
    else $error("ldo still on after thermal shutdown");
  bst_tsd_a: assert property (boost_thermal_shutdown |=>
    !boost_switch_en && !system_power_on && left_shutter_sw == BRT[3])
    else $error("boost still on after thermal shutdown");
  sleep_fall_a: assert property (sleep_fall |=>
    !system_power_on && !ldo_enable)
    else $error("power kept after sleep fall");
endmodule
bind spcl_top spcl_monitor i_mon (.mclk, .resetn, .psel, .penable, .pready,
  .pslverr, .boost_enable_pin, .left_bridge_in_low, .left_bridge_in_high,
  .right_bridge_in_low, .right_bridge_in_high, .sleep_in,
  .ldo_voltage_select, .chg_in, .ldo_thermal_shutdown,
  .boost_thermal_shutdown, .left_shutter_sw, .right_shutter_sw,
  .boost_switch_en, .ldo_enable, .ldo_3v0_select, .system_power_on,
  .charge_status_n_out, .charge_status_n_oe);

//--- sim/spcl_top_tb.sv
// self-checking bench for the shutter pmu control logic
`timescale 1ns/1ns
module spcl_top_tb;
  localparam int TK = 4;
  localparam int PM = 20;
  localparam int FM = 40;
  localparam spcl_pkg::spcl_bridge_t BRT [4] = '{spcl_pkg::BR_OPEN,
    spcl_pkg::BR_PLUS, spcl_pkg::BR_MINUS, spcl_pkg::BR_GND};
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic bst, sel, wake, ltsd, btsd, csi, cse, irq, sw_en, ldo_en, l3v, pwr;
  logic flip, drop, sleep;
  logic [1:0] cl, cr, pl, pr;
  spcl_pkg::spcl_chg_in_t chg;
  spcl_pkg::spcl_slow_t slow;
  spcl_pkg::spcl_bridge_t lsw, rsw, b;
  int error_cnt, checked, seed;
  assign csi = cse ? 1'b0 : 1'b1;
  spcl_top #(.TICK_CYC_P(TK), .PRE_MS_P(PM), .FAST_MS_P(FM)) i_dut (
    .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .boost_enable_pin(bst),
    .left_bridge_in_low(pl[0]), .left_bridge_in_high(pl[1]),
    .right_bridge_in_low(pr[0]), .right_bridge_in_high(pr[1]),
    .sleep_in(sleep), .ldo_voltage_select(sel), .wake_request(wake),
    .chg_in(chg), .slow_in(slow), .ldo_thermal_shutdown(ltsd),
    .boost_thermal_shutdown(btsd), .left_shutter_sw(lsw),
    .right_shutter_sw(rsw), .boost_switch_en(sw_en), .ldo_enable(ldo_en),
    .ldo_3v0_select(l3v), .system_power_on(pwr),
    .charge_status_n_in(csi), .charge_status_n_out(),
    .charge_status_n_oe(cse), .irq);
  spcl_host i_host (.mclk, .resetn, .flip, .cmd_l(cl), .cmd_r(cr),
    .sleep_drop(drop), .pair_l(pl), .pair_r(pr), .sleep_in(sleep));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  function automatic spcl_pkg::spcl_bridge_t exp_br(input logic [1:0] p,
    input logic on);
    return on ? BRT[p] : spcl_pkg::BR_GND;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(5000);
    error_cnt++;
    final_report;
  end
  initial begin
    seed = 32'h0ed3;
    error_cnt = 0;
    checked = 0;
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {bst, sel, wake, ltsd, btsd, flip, drop, cl, cr} = '0;
    chg = '0;
    slow = '0;
    cyc(5);
    resetn <= 1'b1;
    rdchk(spcl_pkg::A_CTRL, 32'h1, 32'h1);
    rdchk(spcl_pkg::A_INT_EN, 32'h1f, 32'h0);
    rdchk(8'h18, 32'hffffffff, 32'h0);
    chk(err, 1'b1);
    $display("test registers done");
    for (int i = 0; i < 24; i++) begin
      cl <= i[1:0];
      cr <= 2'($random(seed));
      bst <= (i % 6) != 0;
      sel <= 1'($random(seed));
      cyc(4);
      chk(lsw, exp_br(pl, bst));
      chk(rsw, exp_br(pr, bst));
      chk(l3v, sel);
    end
    flip <= 1'b1;
    cyc(4);
    b = lsw;
    cyc(1);
    chk(lsw ^ b, 32'hf);
    chk(lsw ^ rsw, 32'hf);
    flip <= 1'b0;
    $display("test bridges done");
    apb(1'b1, spcl_pkg::A_INT_EN, 32'h1);
    chg.vin_present <= 1'b1;
    cyc(3);
    chk(cse, 1'b1);
    cyc(PM * TK * 3 / 4);
    rdchk(spcl_pkg::A_STATUS, 32'h7, 32'h1);
    cyc(PM * TK / 4 + 16);
    rdchk(spcl_pkg::A_STATUS, 32'h7, 32'h5);
    chk(cse, 1'b0);
    rdchk(spcl_pkg::A_INT_STAT, 32'h1, 32'h1);
    chk(irq, 1'b1);
    apb(1'b1, spcl_pkg::A_INT_EN, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    apb(1'b1, spcl_pkg::A_INT_EN, 32'h1);
    cyc(2);
    chk(irq, 1'b1);
    apb(1'b1, spcl_pkg::A_INT_CLR, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    $display("test precharge done");
    chg <= '0;
    slow <= '{1'b1, 1'b0, 1'b0, 8'h80};
    cyc(3);
    chg <= 6'h20;
    cyc(3);
    rdchk(spcl_pkg::A_STATUS, 32'h7, 32'h1);
    chg <= 6'h28;
    cyc(3);
    rdchk(spcl_pkg::A_STATUS, 32'h7, 32'h2);
    cyc(FM * TK * 3 / 2);
    rdchk(spcl_pkg::A_STATUS, 32'h7, 32'h2);
    cyc(FM * TK / 2 + 24);
    rdchk(spcl_pkg::A_STATUS, 32'h7, 32'h5);
    rdchk(spcl_pkg::A_TIMER, 32'h01ffffff, 32'h0);
    chg <= '0;
    cyc(3);
    chg <= 6'h2c;
    cyc(4);
    rdchk(spcl_pkg::A_STATUS, 32'h7, 32'h3);
    chk(cse, 1'b1);
    chg <= 6'h2a;
    cyc(3);
    chk(cse, 1'b0);
    rdchk(spcl_pkg::A_STATUS, 32'h7, 32'h4);
    chg <= 6'h29;
    cyc(3);
    chk(cse, 1'b1);
    chg <= 6'h39;
    cyc(3);
    chk(cse, 1'b0);
    apb(1'b1, spcl_pkg::A_CTRL, 32'h0);
    chg <= 6'h20;
    cyc(3);
    rdchk(spcl_pkg::A_STATUS, 32'h7, 32'h0);
    apb(1'b1, spcl_pkg::A_CTRL, 32'h1);
    chg <= '0;
    $display("test fast charge done");
    for (int k = 0; k < 3; k++) begin
      ltsd <= k == 0;
      btsd <= k == 1;
      drop <= k == 2;
      cyc(1);
      ltsd <= 1'b0;
      btsd <= 1'b0;
      cyc(3);
      chk(pwr, 1'b0);
      chk(ldo_en, 1'b0);
      chk(sw_en, 1'b0);
      drop <= 1'b0;
      wake <= 1'b1;
      cyc(1);
      wake <= 1'b0;
      cyc(3);
      chk(pwr, 1'b1);
    end
    rdchk(spcl_pkg::A_INT_STAT, 32'he, 32'he);
    $display("test power done");
    final_report;
  end
endmodule
